// file: rtl/cmpirq_pkg.sv
// Package of the comparator interrupt enable and flag block.
// Assumes a 32-bit AXI4-Lite bus; register byte address is index * 4.
package cmpirq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_EN_CLR    = 6'h04;
    localparam logic [5:0] IDX_EN_SET    = 6'h05;
    localparam logic [5:0] IDX_FLAG      = 6'h06;
    localparam logic [5:0] IDX_WINDOW_CONTROL_REG   = 6'h08;
    localparam logic [5:0] IDX_CMP_STATE = 6'h09;

    // Bit positions shared by enable and flag registers
    localparam int BIT_CMP_A = 0;
    localparam int BIT_CMP_B = 1;
    localparam int BIT_WINDOW_ZERO_EVENT  = 4;
    localparam logic [7:0] IRQ_MASK = 8'h13;

    // Window control fields
    localparam int WC_BIT_WEN   = 0;
    localparam int WC_SEL_LSB   = 1;
    localparam logic [7:0] WC_MASK = 8'h07;

    // Reset values
    localparam logic [7:0] RST_EN      = 8'h00;
    localparam logic [7:0] RST_FLAG    = 8'h00;
    localparam logic [7:0] RST_WINDOW_CONTROL_REG = 8'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Window interrupt selection codes
    typedef enum logic [1:0] {
        WSEL_ABOVE,
        WSEL_INSIDE,
        WSEL_BELOW,
        WSEL_OUTSIDE
    } cmpirq_wsel_e;

    // One captured register write
    typedef struct packed {
        logic [5:0]  idx;
        logic [31:0] data;
        logic [3:0]  strb;
    } cmpirq_wreq_s;

endpackage

// file: rtl/cmpirq_sync.sv
// Two-stage synchroniser for asynchronous comparator levels.
// Assumes inputs are quasi-static levels from the analog side.
`timescale 1ns/100ps
module cmpirq_sync #(
    parameter int W = 2
) (
    input  wire logic         i_clk_sys, // System clock
    input  wire logic         i_sys_rst, // Synchronous reset
    input  wire logic [W-1:0] i_async,   // Asynchronous levels
    output logic      [W-1:0] o_sync     // Synchronised levels
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // First stage is read only by the second
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // cmpirq_sync

// file: rtl/cmpirq_top.sv
// Interrupt enable and flag logic of a two-channel analog comparator.
// Assumes an AXI4-Lite master and a same-clock write-protect level.
`timescale 1ns/100ps

// Operation
// - A single write of one to a set-enable bit enables that source.
// - Set-enable and clear-enable read back one shared enable state.
// - Writing zero to a set-enable bit leaves that enable unchanged.
// - Window-zero enable is bit 4; writing one there enables it.
// - Reading set-enable bit 4 returns the window-zero enable state.
// - Channel enables are bits 1 and 0; writing one enables them.
// - Reading set-enable bits 1 and 0 returns the channel enables.
// - Set-enable at index 0x05, resets to zero, refused while protected.
// - Window-zero flag sets on the condition chosen by the selection.
// - Interrupt is asserted while window-zero flag and enable are one.
module cmpirq_top (
    input  wire logic        i_clk_sys,       // System clock
    input  wire logic        i_sys_rst,       // Sync reset, active high
    input  wire logic [1:0]  i_cmp_out,       // Comparator outputs, async
    input  wire logic        i_wr_protect,    // Write protection level
    input  wire logic [7:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [7:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    output logic             o_irq            // Interrupt, level high
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte address to register index
    function automatic logic [5:0] addr_idx(input logic [7:0] a);
        return a[7:2];
    endfunction

    // Index is a mapped register
    function automatic logic idx_mapped(input logic [5:0] i);
        return (i == cmpirq_pkg::IDX_EN_CLR) ||
               (i == cmpirq_pkg::IDX_EN_SET) ||
               (i == cmpirq_pkg::IDX_FLAG) ||
               (i == cmpirq_pkg::IDX_WINDOW_CONTROL_REG) ||
               (i == cmpirq_pkg::IDX_CMP_STATE);
    endfunction

    // Index belongs to the protected enable pair
    function automatic logic idx_guarded(input logic [5:0] i);
        return (i == cmpirq_pkg::IDX_EN_CLR) ||
               (i == cmpirq_pkg::IDX_EN_SET);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Declarations

    cmpirq_pkg::cmpirq_wreq_s wreq_reg;
    logic        awready_reg, wready_reg, bvalid_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic        arready_reg, rvalid_reg;
    logic [31:0] rdata_reg, rd_word;
    logic        wr_do, wr_ok;
    logic [7:0]  wr_byte, en_reg, flag_reg, window_control_reg_reg;
    logic        irq_reg;
    logic [1:0]  cmp_sync;
    logic [1:0]  cmp_prev_reg;
    logic [2:0]  arm_reg;
    logic        win_prev_reg;
    logic        win_cond;
    logic        win_inside;
    logic [7:0]  set_evt;
    logic [7:0]  clr_req;
    cmpirq_pkg::cmpirq_wsel_e wsel;

    ////////////////////////////////////////////////////////////////////
    // Write channel

    // Write performed once both halves are held and no response waits
    assign wr_do   = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_byte = wreq_reg.strb[0] ? wreq_reg.data[7:0] : 8'h00;
    assign wr_ok   = idx_mapped(wreq_reg.idx) &&
                     !(idx_guarded(wreq_reg.idx) && i_wr_protect);

    // Address and data taken in either order, one write at a time
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            wreq_reg    <= '0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg  <= 1'b0;
                wreq_reg.idx <= addr_idx(s_axi_awaddr);
            end
            if (s_axi_wvalid && wready_reg) begin
                wready_reg    <= 1'b0;
                wreq_reg.data <= s_axi_wdata;
                wreq_reg.strb <= s_axi_wstrb;
            end
            if (bvalid_reg && s_axi_bready) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // Response; protected or unmapped writes answer SLVERR
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= cmpirq_pkg::RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? cmpirq_pkg::RESP_OKAY
                                : cmpirq_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel

    // Read mux; both enable views show one state
    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_idx(s_axi_araddr))
            cmpirq_pkg::IDX_EN_CLR:    rd_word[7:0] = en_reg;
            cmpirq_pkg::IDX_EN_SET:    rd_word[7:0] = en_reg;
            cmpirq_pkg::IDX_FLAG:      rd_word[7:0] = flag_reg;
            cmpirq_pkg::IDX_WINDOW_CONTROL_REG:   rd_word[7:0] = window_control_reg_reg;
            cmpirq_pkg::IDX_CMP_STATE: begin
                rd_word[1:0] = cmp_sync;
                rd_word[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT] = win_inside;
            end
            default:                   rd_word = 32'h0000_0000;
        endcase
    end

    // Address taken, data returned next cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= cmpirq_pkg::RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= idx_mapped(addr_idx(s_axi_araddr))
                           ? cmpirq_pkg::RESP_OKAY
                           : cmpirq_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enable state and window control

    // Set view ORs ones in, clear view removes them
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            en_reg <= cmpirq_pkg::RST_EN;
        end else if (wr_do && wr_ok) begin
            if (wreq_reg.idx == cmpirq_pkg::IDX_EN_SET)
                en_reg <= en_reg |
                    (wr_byte & cmpirq_pkg::IRQ_MASK);
            else if (wreq_reg.idx == cmpirq_pkg::IDX_EN_CLR)
                en_reg <= en_reg &
                    ~(wr_byte & cmpirq_pkg::IRQ_MASK);
        end
    end

    // Window enable and selection
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            window_control_reg_reg <= cmpirq_pkg::RST_WINDOW_CONTROL_REG;
        end else if (wr_do && wr_ok &&
                     wreq_reg.idx == cmpirq_pkg::IDX_WINDOW_CONTROL_REG) begin
            window_control_reg_reg <= wr_byte & cmpirq_pkg::WC_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Comparator events

    cmpirq_sync #(
        .W (2)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_cmp_out),
        .o_sync    (cmp_sync)
    );

    // Window position from the two channel outputs
    assign win_inside = cmp_sync[0] && !cmp_sync[1];
    assign wsel = cmpirq_pkg::cmpirq_wsel_e'(
        window_control_reg_reg[cmpirq_pkg::WC_SEL_LSB +: 2]);

    // Condition chosen by the window selection
    always_comb begin
        case (wsel)
            cmpirq_pkg::WSEL_ABOVE:   win_cond = cmp_sync[0] && cmp_sync[1];
            cmpirq_pkg::WSEL_INSIDE:  win_cond = win_inside;
            cmpirq_pkg::WSEL_BELOW:   win_cond = !cmp_sync[0] && !cmp_sync[1];
            cmpirq_pkg::WSEL_OUTSIDE: win_cond = !win_inside;
            default:                  win_cond = 1'b0;
        endcase
    end

    // Previous samples; armed once the synchroniser shows the real pin
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cmp_prev_reg <= 2'h0;
            arm_reg      <= 3'h0;
            win_prev_reg <= 1'b0;
        end else begin
            cmp_prev_reg <= cmp_sync;
            arm_reg      <= {arm_reg[1:0], 1'b1};
            win_prev_reg <= win_cond;
        end
    end

    // Channel toggle and window entry events
    always_comb begin
        set_evt = 8'h00;
        set_evt[cmpirq_pkg::BIT_CMP_A] = arm_reg[2] &&
            (cmp_sync[0] != cmp_prev_reg[0]);
        set_evt[cmpirq_pkg::BIT_CMP_B] = arm_reg[2] &&
            (cmp_sync[1] != cmp_prev_reg[1]);
        set_evt[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT] = arm_reg[2] && win_cond &&
            !win_prev_reg &&
            window_control_reg_reg[cmpirq_pkg::WC_BIT_WEN];
    end

    ////////////////////////////////////////////////////////////////////
    // Flags and interrupt

    // Write-one-to-clear request on the flag register
    assign clr_req = (wr_do && wreq_reg.idx == cmpirq_pkg::IDX_FLAG)
                     ? (wr_byte & cmpirq_pkg::IRQ_MASK) : 8'h00;

    // Sticky flags; a new event wins over a clear
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            flag_reg <= cmpirq_pkg::RST_FLAG;
        end else begin
            flag_reg <= (flag_reg & ~clr_req) | set_evt;
        end
    end

    // Level interrupt from enabled flags
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flag_reg & en_reg);
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign o_irq         = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    logic set_wr, clr_wr, flag_wr;
    assign set_wr  = wr_do && wreq_reg.idx == cmpirq_pkg::IDX_EN_SET;
    assign clr_wr  = wr_do && wreq_reg.idx == cmpirq_pkg::IDX_EN_CLR;
    assign flag_wr = wr_do && wreq_reg.idx == cmpirq_pkg::IDX_FLAG;

    sequence s_set_write;
        set_wr && !i_wr_protect && wreq_reg.strb[0];
    endsequence
    property p_set_enables;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_set_write |=> ((en_reg & $past(wr_byte) & cmpirq_pkg::IRQ_MASK)
                        == ($past(wr_byte) & cmpirq_pkg::IRQ_MASK));
    endproperty
    a_set_enables: assert property (p_set_enables)
        else $error("set-enable write did not enable");
    property p_shared_read;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_axi_arvalid && arready_reg &&
         addr_idx(s_axi_araddr) == cmpirq_pkg::IDX_EN_CLR)
        |=> rdata_reg[7:0] == $past(en_reg);
    endproperty
    a_shared_read: assert property (p_shared_read)
        else $error("clear-enable read differs from enable state");
    property p_zero_keeps;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        set_wr |=> ((en_reg ^ $past(en_reg)) & ~$past(wr_byte)) == 8'h00;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("zero written to set-enable changed a bit");
    property p_win_enable;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_set_write ##0 wr_byte[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT]
        |=> en_reg[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT] && s_axi_bvalid;
    endproperty
    a_win_enable: assert property (p_win_enable)
        else $error("window enable not set by bit 4 write");
    property p_set_read;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_axi_arvalid && arready_reg &&
         addr_idx(s_axi_araddr) == cmpirq_pkg::IDX_EN_SET)
        |=> rvalid_reg && rdata_reg[4] == $past(en_reg[4])
            && rdata_reg[1:0] == $past(en_reg[1:0]);
    endproperty
    a_set_read: assert property (p_set_read)
        else $error("set-enable read wrong");
    property p_chan_enable;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_set_write ##0 (wr_byte[1:0] == 2'h3) |=> en_reg[1:0] == 2'h3;
    endproperty
    a_chan_enable: assert property (p_chan_enable)
        else $error("channel enables not set");
    property p_protect;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (set_wr || clr_wr) && i_wr_protect
        |=> $stable(en_reg) && bresp_reg == cmpirq_pkg::RESP_SLVERR;
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected enable write was not refused");
    property p_win_flag;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        arm_reg[2] && window_control_reg_reg[cmpirq_pkg::WC_BIT_WEN] && $rose(win_cond)
        |=> flag_reg[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT];
    endproperty
    a_win_flag: assert property (p_win_flag)
        else $error("window flag not set on selected condition");
    property p_irq;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        flag_reg[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT] && en_reg[cmpirq_pkg::BIT_WINDOW_ZERO_EVENT]
        |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for window flag");
    property p_flag_clear;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        flag_wr && wreq_reg.strb[0] && wreq_reg.data[1:0] == 2'h3
        && set_evt[1:0] == 2'h0 |=> flag_reg[1:0] == 2'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by writing one");

endmodule // cmpirq_top

// file: tb/cmpirq_tb.sv
// Self-checking bench of the comparator interrupt enable and flag block.
// Assumes the package register map and an AXI4-Lite slave on one clock.
`timescale 1ns/100ps
module tb;

////////////////////////////////////////////////////////////////////////////
    logic        i_clk_sys;
    logic        i_sys_rst;
    logic [1:0]  i_cmp_out;
    logic        i_wr_protect;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        o_irq;
    int          num_errors;
    int          comparisons;

    // Byte addresses, bit masks and responses
    localparam logic [7:0]  A_CLR = {cmpirq_pkg::IDX_EN_CLR, 2'b00};
    localparam logic [7:0]  A_SET = {cmpirq_pkg::IDX_EN_SET, 2'b00};
    localparam logic [7:0]  A_FLG = {cmpirq_pkg::IDX_FLAG, 2'b00};
    localparam logic [7:0]  A_WC  = {cmpirq_pkg::IDX_WINDOW_CONTROL_REG, 2'b00};
    localparam logic [7:0]  A_CS  = {cmpirq_pkg::IDX_CMP_STATE, 2'b00};
    localparam logic [7:0]  A_BAD = 8'h1c;
    localparam logic [31:0] EA    = 32'h1 << cmpirq_pkg::BIT_CMP_A;
    localparam logic [31:0] EB    = 32'h1 << cmpirq_pkg::BIT_CMP_B;
    localparam logic [31:0] EW    = 32'h1 << cmpirq_pkg::BIT_WINDOW_ZERO_EVENT;
    localparam logic [1:0]  OK    = cmpirq_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR   = cmpirq_pkg::RESP_SLVERR;

////////////////////////////////////////////////////////////////////////////
    cmpirq_top uut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_cmp_out(i_cmp_out), .i_wr_protect(i_wr_protect),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .o_irq(o_irq)
    );

    // Clock at 250 MHz
    always #2 i_clk_sys = ~i_clk_sys;

////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Value compare
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask

    // Bounded wait ran out
    task automatic hang(input string msg);
        num_errors++;
        $display("mismatch at %0t: timeout on %s", $time, msg);
        test_done();
    endtask

    // One AXI4-Lite write, address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        int   n;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        r     = 2'h3;
        @(posedge i_clk_sys);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk_sys);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100)
            hang("write");
    endtask

    // One AXI4-Lite read
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ar_ok;
        int   n;
        ar_ok = 1'b0;
        r     = 2'h3;
        d     = 32'h0;
        @(posedge i_clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk_sys);
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100)
            hang("read");
    endtask

    // Write and judge the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, {30'h0, er}, "write response");
    endtask

    // Read and judge data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, ed, "read data");
        check({30'h0, r}, {30'h0, er}, "read response");
    endtask

    // Interrupt level at the next edge
    task automatic chk_irq(input logic e);
        @(posedge i_clk_sys);
        check({31'h0, o_irq}, {31'h0, e}, "interrupt");
    endtask

////////////////////////////////////////////////////////////////////////////
    // Reset contents
    task automatic t_reset;
        rd(A_SET, 32'h0, OK);
        rd(A_CLR, 32'h0, OK);
        rd(A_FLG, 32'h0, OK);
        chk_irq(1'b0);
    endtask

    // Set-only enables, shared with the clear register
    task automatic t_enable;
        wr(A_SET, EA, OK);
        rd(A_SET, EA, OK);
        wr(A_SET, EB, OK);
        rd(A_SET, EA | EB, OK);
        wr(A_SET, 32'h0, OK);
        rd(A_SET, EA | EB, OK);
        wr(A_SET, EW, OK);
        rd(A_SET, EA | EB | EW, OK);
        rd(A_CLR, EA | EB | EW, OK);
        wr(A_CLR, EA, OK);
        rd(A_SET, EB | EW, OK);
        rd(A_SET, EB | EW, OK);
    endtask

    // Protected enables and an unmapped word
    task automatic t_protect;
        i_wr_protect <= 1'b1;
        wr(A_SET, EA, ERR);
        wr(A_CLR, EB, ERR);
        rd(A_SET, EB | EW, OK);
        i_wr_protect <= 1'b0;
        wr(A_BAD, 32'hff, ERR);
        rd(A_BAD, 32'h0, ERR);
        wr(A_CLR, EB, OK);
        rd(A_SET, EW, OK);
    endtask

    // Each window selection: entry sets the flag and the interrupt
    task automatic t_window;
        logic [1:0] st [4];
        logic [1:0] en [4];
        int         s;
        logic [31:0] wc;
        st = '{2'b00, 2'b00, 2'b11, 2'b01};
        en = '{2'b11, 2'b01, 2'b00, 2'b11};
        for (s = 0; s < 4; s++) begin
            i_cmp_out <= st[s];
            repeat (8) @(posedge i_clk_sys);
            wc = (32'(s) << cmpirq_pkg::WC_SEL_LSB) |
                 (32'h1 << cmpirq_pkg::WC_BIT_WEN);
            wr(A_WC, wc, OK);
            rd(A_WC, wc, OK);
            wr(A_FLG, 32'hff, OK);
            rd(A_FLG, 32'h0, OK);
            chk_irq(1'b0);
            i_cmp_out <= en[s];
            repeat (8) @(posedge i_clk_sys);
            rd(A_CS, 32'(en[s]) | ((en[s] == 2'b01) ? EW : 32'h0),
               OK);
            rd(A_FLG, EW | 32'(st[s] ^ en[s]), OK);
            chk_irq(1'b1);
            wr(A_FLG, EW, OK);
            rd(A_FLG, 32'(st[s] ^ en[s]), OK);
            chk_irq(1'b0);
        end
    endtask

////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        num_errors    = 0;
        comparisons   = 0;
        i_clk_sys     = 1'b0;
        i_sys_rst     = 1'b1;
        i_cmp_out     = 2'b00;
        i_wr_protect  = 1'b0;
        s_axi_awaddr  = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        t_reset();
        t_enable();
        t_protect();
        t_window();
        test_done();
    end

endmodule // tb
